// ==== verilog/temp_sensor_regmap.sv ====
// Holding register map, request handling and restart control of the sensor
`timescale 1ns/1ns
// Notes on behaviour
// - Lamp blinks one-second period while communicating
// - Lamp blinks three-second period without communication
// - Button at power-up: lit, flash, lit
// - Release after tenth second restores defaults
// - Station address at 10, default 1, 1..247
// - Line speed at 11, listed rates, default 19200
// - Framing at 12, values 1..3, default 1
// - Written speed and framing never apply; restart restores defaults before they load
// - Word order at 13 selects temperature halves
// - Address field used directly as register index
// - Temperatures as floats at 100 and 200
// - Unavailable float reads as not-a-number
// - Float probe at 82 and 84
// - Signed probes at 86, 87, 89
// - Unsigned probes at 91, 92, 94
module temp_sensor_regmap
  import sensor_regmap_pkg::*;
#(
  parameter int unsigned OK_HALF = OK_HALF_CYC,
  parameter int unsigned IDLE_HALF = IDLE_HALF_CYC,
  parameter int unsigned LIT_TIME = LIT_CYC,
  parameter int unsigned FLASH_TIME = FLASH_CYC,
  parameter int unsigned FLASH_HALF = FLASH_HALF_CYC,
  parameter int unsigned COMM_TIMEOUT = COMM_TIMEOUT_CYC,
  // Identity values below are arbitrary
  parameter logic [15:0] SUBTYPE_ID = 16'h005A,
  parameter logic [15:0] FW_REVISION = 16'h0100,
  parameter logic [511:0] WEB_TEXT = {120'h6578_616D_706C_652E_696E_7661_6C69_64, 392'h0}
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire reg_req_t req,
  output reg_resp_t resp,
  input wire logic comm_frame,
  input wire logic config_button,
  input wire logic [31:0] temp_celsius_in,
  input wire logic [31:0] temp_fahrenheit_in,
  input wire logic temp_valid,
  output logic [15:0] station_address,
  output link_cfg_t link_cfg,
  output logic status_led,
  output logic restart_pulse
);

  typedef struct packed {
    logic [15:0] station;
    logic [15:0] speed;
    framing_t framing;
    order_t order;
    link_cfg_t active;
    logic booted;
    logic restart;
    reg_resp_t resp;
  } map_state_t;

  map_state_t cur_reg;
  map_state_t cur_next;
  logic writable;
  logic value_ok;
  logic restore_defaults;
  logic rd_hit;
  logic [15:0] rd_word;
  logic [15:0] web_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Picks one half of a 32-bit value; second selects the upper index
  function automatic logic [15:0] pick_word(input logic [31:0] value, input logic second,
                                            input logic hi_first);
    logic first_hi;
    first_hi = hi_first ^ second;
    pick_word = first_hi ? value[31:16] : value[15:0];
  endfunction : pick_word

  // Two-word window test
  function automatic logic in_pair(input logic [15:0] addr, input logic [15:0] base);
    in_pair = (addr == base) || (addr == base + 16'h0001);
  endfunction : in_pair

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  settings_check u_check (
    .addr(req.addr),
    .wdata(req.wdata),
    .writable(writable),
    .value_ok(value_ok)
  );

  status_indicator #(
    .OK_HALF(OK_HALF),
    .IDLE_HALF(IDLE_HALF),
    .LIT_TIME(LIT_TIME),
    .FLASH_TIME(FLASH_TIME),
    .FLASH_HALF(FLASH_HALF),
    .COMM_TIMEOUT(COMM_TIMEOUT)
  ) u_indicator (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .config_button(config_button),
    .activity(comm_frame | req.valid),
    .status_led(status_led),
    .restore_defaults(restore_defaults)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  assign web_idx = req.addr - ADDR_WEB_TEXT;

  always_comb begin
    logic [31:0] temp_c;
    logic [31:0] temp_f;
    logic hi_first;
    temp_c = temp_valid ? temp_celsius_in : FLOAT_NAN;
    temp_f = temp_valid ? temp_fahrenheit_in : FLOAT_NAN;
    hi_first = (cur_reg.order == HIGH_WORD_FIRST);
    rd_hit = 1'b1;
    rd_word = 16'h0000;
    if (req.addr == ADDR_STATION) begin
      rd_word = cur_reg.station;
    end else if (req.addr == ADDR_LINE_SPEED) begin
      rd_word = cur_reg.speed;
    end else if (req.addr == ADDR_FRAMING) begin
      rd_word = cur_reg.framing;
    end else if (req.addr == ADDR_WORD_ORDER) begin
      rd_word = cur_reg.order;
    end else if (req.addr == ADDR_SUBTYPE) begin
      rd_word = SUBTYPE_ID;
    end else if (req.addr == ADDR_FW_REV) begin
      rd_word = FW_REVISION;
    end else if (req.addr >= ADDR_WEB_TEXT && web_idx < WEB_TEXT_WORDS) begin
      rd_word = 16'(WEB_TEXT >> (16 * (31 - int'(web_idx[4:0]))));
    end else if (in_pair(req.addr, ADDR_FLOAT_HI_FIRST)) begin
      rd_word = pick_word(FLOAT_PROBE, req.addr[0], 1'b1);
    end else if (in_pair(req.addr, ADDR_FLOAT_LO_FIRST)) begin
      rd_word = pick_word(FLOAT_PROBE, req.addr[0], 1'b0);
    end else if (req.addr == ADDR_S16) begin
      rd_word = S16_PROBE;
    end else if (in_pair(req.addr, ADDR_S32_HI_FIRST)) begin
      rd_word = pick_word(S32_PROBE, ~req.addr[0], 1'b1);
    end else if (in_pair(req.addr, ADDR_S32_LO_FIRST)) begin
      rd_word = pick_word(S32_PROBE, ~req.addr[0], 1'b0);
    end else if (req.addr == ADDR_U16) begin
      rd_word = U16_PROBE;
    end else if (in_pair(req.addr, ADDR_U32_HI_FIRST)) begin
      rd_word = pick_word(U32_PROBE, req.addr[0], 1'b1);
    end else if (in_pair(req.addr, ADDR_U32_LO_FIRST)) begin
      rd_word = pick_word(U32_PROBE, req.addr[0], 1'b0);
    end else if (in_pair(req.addr, ADDR_TEMP_C)) begin
      rd_word = pick_word(temp_c, req.addr[0], hi_first);
    end else if (in_pair(req.addr, ADDR_TEMP_F)) begin
      rd_word = pick_word(temp_f, req.addr[0], hi_first);
    end else begin
      rd_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request handling and settings

  always_comb begin
    cur_next = cur_reg;
    cur_next.resp = '0;
    cur_next.restart = 1'b0;
    // Latch link settings once per start
    if (!cur_reg.booted) begin
      cur_next.active.line_speed = cur_reg.speed;
      cur_next.active.framing = cur_reg.framing;
      cur_next.booted = 1'b1;
    end
    if (req.valid) begin
      cur_next.resp.valid = 1'b1;
      if (req.fc == FC_READ_HOLDING) begin
        if (rd_hit) begin
          cur_next.resp.rdata = rd_word;
        end else begin
          cur_next.resp.exception = 1'b1;
          cur_next.resp.exc_code = EXC_ILLEGAL_ADDRESS;
        end
      end else if (req.fc == FC_WRITE_SINGLE) begin
        if (!writable) begin
          cur_next.resp.exception = 1'b1;
          cur_next.resp.exc_code = EXC_ILLEGAL_ADDRESS;
        end else if (!value_ok) begin
          cur_next.resp.exception = 1'b1;
          cur_next.resp.exc_code = EXC_ILLEGAL_VALUE;
        end else begin
          cur_next.resp.rdata = req.wdata;
          if (req.addr == ADDR_STATION) begin
            cur_next.station = req.wdata;
          end else if (req.addr == ADDR_LINE_SPEED) begin
            cur_next.speed = req.wdata;
          end else if (req.addr == ADDR_FRAMING) begin
            cur_next.framing = framing_t'(req.wdata);
          end else begin
            cur_next.order = order_t'(req.wdata);
          end
        end
      end else begin
        cur_next.resp.exception = 1'b1;
        cur_next.resp.exc_code = EXC_ILLEGAL_FUNCTION;
      end
    end
    // Factory restore overrides any write in the same cycle
    if (restore_defaults) begin
      cur_next.station = STATION_RST;
      cur_next.speed = SPEED_RST;
      cur_next.framing = FRAMING_RST;
      cur_next.order = ORDER_RST;
      cur_next.booted = 1'b0;
      cur_next.restart = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur_reg <= '{station: STATION_RST, speed: SPEED_RST, framing: FRAMING_RST, order: ORDER_RST,
                   active: '{line_speed: SPEED_RST, framing: FRAMING_RST}, booted: 1'b0, restart: 1'b0,
                   resp: '0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign resp = cur_reg.resp;
  assign station_address = cur_reg.station;
  assign link_cfg = cur_reg.active;
  assign restart_pulse = cur_reg.restart;

endmodule : temp_sensor_regmap

// ==== verilog/sensor_regmap_pkg.sv ====
// Shared constants, types and timing for the temperature sensor register map
package sensor_regmap_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned BLINK_OK_PERIOD_MS = 1000;
  localparam int unsigned BLINK_IDLE_PERIOD_MS = 3000;
  localparam int unsigned RESTORE_LIT_MS = 3000;
  localparam int unsigned RESTORE_FLASH_MS = 7000;
  localparam int unsigned RESTORE_FLASH_PERIOD_MS = 500;
  localparam int unsigned COMM_TIMEOUT_MS = 3000;
  localparam int unsigned OK_HALF_CYC = BLINK_OK_PERIOD_MS * CYC_PER_MS / 2;
  localparam int unsigned IDLE_HALF_CYC = BLINK_IDLE_PERIOD_MS * CYC_PER_MS / 2;
  localparam int unsigned LIT_CYC = RESTORE_LIT_MS * CYC_PER_MS;
  localparam int unsigned FLASH_CYC = RESTORE_FLASH_MS * CYC_PER_MS;
  localparam int unsigned FLASH_HALF_CYC = RESTORE_FLASH_PERIOD_MS * CYC_PER_MS / 2;
  localparam int unsigned COMM_TIMEOUT_CYC = COMM_TIMEOUT_MS * CYC_PER_MS;
  localparam logic [1:0] BUTTON_SETTLE = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices (protocol data unit address)
  localparam logic [15:0] ADDR_STATION = 16'h000A;
  localparam logic [15:0] ADDR_LINE_SPEED = 16'h000B;
  localparam logic [15:0] ADDR_FRAMING = 16'h000C;
  localparam logic [15:0] ADDR_WORD_ORDER = 16'h000D;
  localparam logic [15:0] ADDR_SUBTYPE = 16'h000E;
  localparam logic [15:0] ADDR_FW_REV = 16'h000F;
  localparam logic [15:0] ADDR_WEB_TEXT = 16'h0012;
  localparam logic [15:0] WEB_TEXT_WORDS = 16'h0020;
  localparam logic [15:0] ADDR_FLOAT_HI_FIRST = 16'h0052;
  localparam logic [15:0] ADDR_FLOAT_LO_FIRST = 16'h0054;
  localparam logic [15:0] ADDR_S16 = 16'h0056;
  localparam logic [15:0] ADDR_S32_HI_FIRST = 16'h0057;
  localparam logic [15:0] ADDR_S32_LO_FIRST = 16'h0059;
  localparam logic [15:0] ADDR_U16 = 16'h005B;
  localparam logic [15:0] ADDR_U32_HI_FIRST = 16'h005C;
  localparam logic [15:0] ADDR_U32_LO_FIRST = 16'h005E;
  localparam logic [15:0] ADDR_TEMP_C = 16'h0064;
  localparam logic [15:0] ADDR_TEMP_F = 16'h00C8;
  localparam int unsigned LOGICAL_BASE = 40001;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and valid sets
  localparam logic [15:0] STATION_RST = 16'h0001;
  localparam logic [15:0] STATION_MIN = 16'h0001;
  localparam logic [15:0] STATION_MAX = 16'h00F7;
  localparam logic [15:0] SPEED_RST = 16'h4B00;
  localparam logic [15:0] SPEED_2400 = 16'h0960;
  localparam logic [15:0] SPEED_4800 = 16'h12C0;
  localparam logic [15:0] SPEED_9600 = 16'h2580;
  localparam logic [15:0] SPEED_19200 = 16'h4B00;
  localparam logic [15:0] SPEED_38400 = 16'h9600;
  localparam logic [15:0] SPEED_57600 = 16'hE100;

  typedef enum logic [15:0] {
    EVEN_PARITY_8D1S = 16'h0001,
    ODD_PARITY_8D1S = 16'h0002,
    NO_PARITY_8D1S = 16'h0003
  } framing_t;

  typedef enum logic [15:0] {
    HIGH_WORD_FIRST = 16'h0001,
    LOW_WORD_FIRST = 16'h0002
  } order_t;

  localparam framing_t FRAMING_RST = EVEN_PARITY_8D1S;
  localparam order_t ORDER_RST = HIGH_WORD_FIRST;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed probe values
  localparam logic [31:0] FLOAT_PROBE = 32'hC11E_6666;
  localparam logic [15:0] S16_PROBE = 16'hFC19;
  localparam logic [31:0] S32_PROBE = 32'hFFFE_7961;
  localparam logic [15:0] U16_PROBE = 16'h03E7;
  localparam logic [31:0] U32_PROBE = 32'h0001_869F;
  localparam logic [31:0] FLOAT_NAN = 32'h7FC0_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Function and exception codes
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic valid;
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic exception;
    logic [7:0] exc_code;
    logic [15:0] rdata;
  } reg_resp_t;

  typedef struct packed {
    logic [15:0] line_speed;
    framing_t framing;
  } link_cfg_t;

endpackage : sensor_regmap_pkg

// ==== verilog/settings_check.sv ====
// Write permission and value checking for the holding registers
`timescale 1ns/1ns
module settings_check
  import sensor_regmap_pkg::*;
(
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  output logic writable,
  output logic value_ok
);

  always_comb begin
    writable = 1'b1;
    value_ok = 1'b0;
    if (addr == ADDR_STATION) begin
      value_ok = (wdata >= STATION_MIN) && (wdata <= STATION_MAX);
    end else if (addr == ADDR_LINE_SPEED) begin
      value_ok = (wdata == SPEED_2400) || (wdata == SPEED_4800) || (wdata == SPEED_9600) ||
                 (wdata == SPEED_19200) || (wdata == SPEED_38400) || (wdata == SPEED_57600);
    end else if (addr == ADDR_FRAMING) begin
      value_ok = (wdata == EVEN_PARITY_8D1S) || (wdata == ODD_PARITY_8D1S) ||
                 (wdata == NO_PARITY_8D1S);
    end else if (addr == ADDR_WORD_ORDER) begin
      value_ok = (wdata == HIGH_WORD_FIRST) || (wdata == LOW_WORD_FIRST);
    end else begin
      writable = 1'b0;
    end
  end

endmodule : settings_check

// ==== verilog/status_indicator.sv ====
// Status lamp patterns and the power-up defaults-restore sequence
`timescale 1ns/1ns
module status_indicator
  import sensor_regmap_pkg::*;
#(
  parameter int unsigned OK_HALF = OK_HALF_CYC,
  parameter int unsigned IDLE_HALF = IDLE_HALF_CYC,
  parameter int unsigned LIT_TIME = LIT_CYC,
  parameter int unsigned FLASH_TIME = FLASH_CYC,
  parameter int unsigned FLASH_HALF = FLASH_HALF_CYC,
  parameter int unsigned COMM_TIMEOUT = COMM_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic config_button,
  input wire logic activity,
  output logic status_led,
  output logic restore_defaults
);

  typedef enum logic [2:0] {
    PH_BOOT = 3'b000,
    PH_LIT_FIRST = 3'b001,
    PH_FLASH = 3'b010,
    PH_LIT_WAIT = 3'b011,
    PH_RUN = 3'b100
  } phase_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [1:0] boot_cnt;
    phase_t phase;
    logic [31:0] phase_cnt;
    logic [31:0] blink_cnt;
    logic [31:0] idle_cnt;
    logic comm_ok;
    logic led;
    logic restore;
  } ind_state_t;

  ind_state_t cur_reg;
  ind_state_t cur_next;

  if (OK_HALF < 1 || IDLE_HALF < 1 || LIT_TIME < 1 || FLASH_TIME < 1 || FLASH_HALF < 1 || COMM_TIMEOUT < 1) begin : g_chk
    $error("status_indicator: every timing count must be at least one cycle");
  end

  always_comb begin
    cur_next = cur_reg;
    cur_next.sync1 = config_button;
    cur_next.sync2 = cur_reg.sync1;
    cur_next.restore = 1'b0;
    // Communication watchdog
    if (activity) begin
      cur_next.idle_cnt = '0;
      cur_next.comm_ok = 1'b1;
    end else if (cur_reg.idle_cnt >= 32'(COMM_TIMEOUT - 1)) begin
      cur_next.comm_ok = 1'b0;
    end else begin
      cur_next.idle_cnt = cur_reg.idle_cnt + 32'h0000_0001;
    end
    case (cur_reg.phase)
      PH_BOOT: begin
        cur_next.boot_cnt = cur_reg.boot_cnt + 2'h1;
        if (cur_reg.boot_cnt == BUTTON_SETTLE) begin
          cur_next.phase_cnt = '0;
          cur_next.blink_cnt = '0;
          cur_next.led = cur_reg.sync2;
          cur_next.phase = cur_reg.sync2 ? PH_LIT_FIRST : PH_RUN;
        end
      end
      PH_LIT_FIRST: begin
        cur_next.led = 1'b1;
        if (!cur_reg.sync2) begin
          cur_next.phase = PH_RUN;
        end else if (cur_reg.phase_cnt >= 32'(LIT_TIME - 1)) begin
          cur_next.phase = PH_FLASH;
          cur_next.phase_cnt = '0;
          cur_next.blink_cnt = '0;
          cur_next.led = 1'b0;
        end else begin
          cur_next.phase_cnt = cur_reg.phase_cnt + 32'h0000_0001;
        end
      end
      PH_FLASH: begin
        if (cur_reg.blink_cnt >= 32'(FLASH_HALF - 1)) begin
          cur_next.blink_cnt = '0;
          cur_next.led = ~cur_reg.led;
        end else begin
          cur_next.blink_cnt = cur_reg.blink_cnt + 32'h0000_0001;
        end
        if (!cur_reg.sync2) begin
          cur_next.phase = PH_RUN;
        end else if (cur_reg.phase_cnt >= 32'(FLASH_TIME - 1)) begin
          cur_next.phase = PH_LIT_WAIT;
          cur_next.led = 1'b1;
        end else begin
          cur_next.phase_cnt = cur_reg.phase_cnt + 32'h0000_0001;
        end
      end
      PH_LIT_WAIT: begin
        cur_next.led = 1'b1;
        if (!cur_reg.sync2) begin
          cur_next.restore = 1'b1;
          cur_next.phase = PH_RUN;
          cur_next.blink_cnt = '0;
        end
      end
      PH_RUN: begin
        if (cur_reg.blink_cnt >= 32'((cur_reg.comm_ok ? OK_HALF : IDLE_HALF) - 1)) begin
          cur_next.blink_cnt = '0;
          cur_next.led = ~cur_reg.led;
        end else begin
          cur_next.blink_cnt = cur_reg.blink_cnt + 32'h0000_0001;
        end
      end
      default: begin
        cur_next.phase = PH_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur_reg <= '{sync1: 1'b0, sync2: 1'b0, boot_cnt: 2'h0, phase: PH_BOOT, phase_cnt: 32'h0000_0000,
                   blink_cnt: 32'h0000_0000, idle_cnt: 32'h0000_0000, comm_ok: 1'b0, led: 1'b0, restore: 1'b0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign status_led = cur_reg.led;
  assign restore_defaults = cur_reg.restore;

endmodule : status_indicator

// ==== testbench/regmap_asserts.sv ====
// Assertions on the register map top-level ports
`timescale 1ns/1ns
module regmap_asserts
  import sensor_regmap_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire reg_req_t req,
  input wire reg_resp_t resp,
  input wire logic comm_frame,
  input wire logic config_button,
  input wire logic [31:0] temp_celsius_in,
  input wire logic [31:0] temp_fahrenheit_in,
  input wire logic temp_valid,
  input wire logic [15:0] station_address,
  input wire link_cfg_t link_cfg,
  input wire logic status_led,
  input wire logic restart_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  property p_answer; req.valid |=> resp.valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer after request");
  property p_quiet; !req.valid |=> !resp.valid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_st_ok;
    req.valid && req.fc == FC_WRITE_SINGLE && req.addr == ADDR_STATION && req.wdata >= STATION_MIN &&
      req.wdata <= STATION_MAX |=> restart_pulse || (!resp.exception && station_address == $past(req.wdata));
  endproperty
  a_st_ok: assert property (p_st_ok) else $error("station write not stored");
  property p_st_bad;
    req.valid && req.fc == FC_WRITE_SINGLE && req.addr == ADDR_STATION && (req.wdata == 16'h0000 ||
      req.wdata > STATION_MAX) |=> restart_pulse ||
      (resp.exception && resp.exc_code == EXC_ILLEGAL_VALUE && $stable(station_address));
  endproperty
  a_st_bad: assert property (p_st_bad) else $error("bad station value taken");
  property p_cfg_hold; $changed(link_cfg) |-> $past(restart_pulse); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("link settings changed without restart");
  property p_float;
    req.valid && req.fc == FC_READ_HOLDING && req.addr == ADDR_FLOAT_HI_FIRST |=> resp.rdata == 16'hc11e;
  endproperty
  a_float: assert property (p_float) else $error("float probe high word wrong");
  property p_s16; req.valid && req.fc == FC_READ_HOLDING && req.addr == ADDR_S16 |=> resp.rdata == 16'hfc19; endproperty
  a_s16: assert property (p_s16) else $error("signed probe wrong");
  property p_u32lo;
    req.valid && req.fc == FC_READ_HOLDING && req.addr == ADDR_U32_LO_FIRST |=> resp.rdata == 16'h869f;
  endproperty
  a_u32lo: assert property (p_u32lo) else $error("unsigned probe low word wrong");
  property p_ro;
    req.valid && req.fc == FC_WRITE_SINGLE && req.addr == ADDR_FLOAT_HI_FIRST
      |=> resp.exception && resp.exc_code == EXC_ILLEGAL_ADDRESS;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write not refused");
  property p_restart;
    restart_pulse |=> !restart_pulse && link_cfg.line_speed == 16'h4b00 && link_cfg.framing == EVEN_PARITY_8D1S;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not restore link defaults");
endmodule : regmap_asserts

// ==== testbench/bus_master_model.sv ====
// Bus master model issuing single-register requests
`timescale 1ns/1ns
module bus_master_model
  import sensor_regmap_pkg::*;
(
  input wire logic clk_sys,
  input wire reg_resp_t resp,
  output reg_req_t req
);
  initial req = '0;
  task automatic xfer(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] d, output reg_resp_t r);
    @(posedge clk_sys);
    req <= '{valid: 1'b1, fc: fc, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
    #1;
    r = resp;
  endtask : xfer
  task automatic read32(input logic [15:0] a, input logic hi, output logic [31:0] v);
    reg_resp_t r0;
    reg_resp_t r1;
    xfer(FC_READ_HOLDING, a, 16'h0000, r0);
    xfer(FC_READ_HOLDING, a + 16'h0001, 16'h0000, r1);
    v = hi ? {r0.rdata, r1.rdata} : {r1.rdata, r0.rdata};
  endtask : read32
endmodule : bus_master_model

// ==== testbench/tb.sv ====
// Self-checking bench for the sensor register map
`timescale 1ns/1ns
module tb;
  import sensor_regmap_pkg::*;
  localparam int OKH = 10;
  localparam int IDH = 30;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic comm_frame = 1'b0;
  logic config_button = 1'b0;
  logic [31:0] temp_c = 32'h0000_0000;
  logic [31:0] temp_f = 32'h0000_0000;
  logic temp_valid = 1'b1;
  logic chatty = 1'b0;
  reg_req_t req;
  reg_resp_t resp;
  logic [15:0] station_address;
  link_cfg_t link_cfg;
  logic status_led;
  logic restart_pulse;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [15:0] speeds [6] = '{SPEED_2400, SPEED_4800, SPEED_9600, SPEED_19200, SPEED_38400, SPEED_57600};
  logic [15:0] probe [14] = '{16'hc11e, 16'h6666, 16'h6666, 16'hc11e, 16'hfc19, 16'hfffe, 16'h7961,
    16'h7961, 16'hfffe, 16'h03e7, 16'h0001, 16'h869f, 16'h869f, 16'h0001};
  temp_sensor_regmap #(.OK_HALF(OKH), .IDLE_HALF(IDH), .LIT_TIME(30), .FLASH_TIME(70), .FLASH_HALF(5),
    .COMM_TIMEOUT(40)) DUT (.clk_sys(clk_sys), .resetn(resetn), .req(req), .resp(resp),
    .comm_frame(comm_frame), .config_button(config_button), .temp_celsius_in(temp_c),
    .temp_fahrenheit_in(temp_f), .temp_valid(temp_valid), .station_address(station_address),
    .link_cfg(link_cfg), .status_led(status_led), .restart_pulse(restart_pulse));
  bus_master_model u_master (.clk_sys(clk_sys), .resp(resp), .req(req));
  ////////////////////////////////////////
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    comm_frame <= chatty && ($urandom_range(0, 3) == 0);
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    test_done;
  end
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic xchk(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] d, input logic [7:0] c,
    input logic [15:0] e);
    reg_resp_t r;
    u_master.xfer(fc, a, d, r);
    chk({6'h00, r.valid, r.exception, r.exc_code, r.rdata}, {7'h01, c != 8'h00, c, (c != 8'h00) ? 16'h0000 : e});
  endtask : xchk
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    xchk(FC_READ_HOLDING, a, 16'h0000, 8'h00, e);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
    xchk(FC_WRITE_SINGLE, a, d, c, d);
  endtask : wr
  task automatic period(output int n);
    logic s;
    for (int k = 0; k < 2; k++) begin
      s = status_led;
      n = 0;
      while (status_led === s && n < 200) begin
        tick;
        n++;
      end
      if (n >= 200) begin
        n_mismatch++;
        test_done;
      end
    end
  endtask : period
  task automatic test_done;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////
  initial begin
    int v;
    int n;
    logic [31:0] w;
    void'($urandom(32'hfe7c_1c30));
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    tick;
    rd(ADDR_STATION, 16'h0001);
    rd(ADDR_LINE_SPEED, 16'h4b00);
    rd(ADDR_FRAMING, 16'h0001);
    rd(ADDR_WORD_ORDER, 16'h0001);
    rd(ADDR_SUBTYPE, 16'h005a);
    rd(ADDR_FW_REV, 16'h0100);
    rd(ADDR_WEB_TEXT, 16'h6578);
    rd(16'h0031, 16'h0000);
    for (int i = 0; i < 14; i++) rd(16'h0052 + 16'(i), probe[i]);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 1 : (i == 1) ? 247 : $urandom_range(1, 247);
      wr(ADDR_STATION, 16'(v), 8'h00);
      chk(32'(station_address), 32'(v));
    end
    wr(ADDR_STATION, 16'h0000, 8'h03);
    wr(ADDR_STATION, 16'(248 + $urandom_range(0, 9000)), 8'h03);
    chk(32'(station_address), 32'(v));
    foreach (speeds[i]) begin
      wr(ADDR_LINE_SPEED, speeds[i], 8'h00);
      rd(ADDR_LINE_SPEED, speeds[i]);
    end
    wr(ADDR_LINE_SPEED, 16'h04d2, 8'h03);
    for (int f = 1; f < 5; f++) wr(ADDR_FRAMING, 16'(f), (f == 4) ? 8'h03 : 8'h00);
    wr(ADDR_WORD_ORDER, 16'h0000, 8'h03);
    chk(link_cfg, 32'h4b00_0001);
    wr(ADDR_FLOAT_HI_FIRST, 16'h0001, 8'h02);
    xchk(8'h10, ADDR_STATION, 16'h0000, 8'h01, 16'h0000);
    xchk(FC_READ_HOLDING, 16'h0040, 16'h0000, 8'h02, 16'h0000);
    for (int o = 1; o < 3; o++) begin
      @(posedge clk_sys);
      temp_c <= $urandom;
      temp_f <= $urandom;
      wr(ADDR_WORD_ORDER, 16'(o), 8'h00);
      u_master.read32(ADDR_TEMP_C, o == 1, w);
      chk(w, temp_c);
      u_master.read32(ADDR_TEMP_F, o == 1, w);
      chk(w, temp_f);
    end
    @(posedge clk_sys);
    temp_valid <= 1'b0;
    u_master.read32(ADDR_TEMP_C, 1'b0, w);
    chk(w, 32'h7fc0_0000);
    @(posedge clk_sys);
    chatty <= 1'b1;
    period(n);
    chk(32'(n), 32'(OKH));
    @(posedge clk_sys);
    chatty <= 1'b0;
    repeat (60) tick;
    period(n);
    chk(32'(n), 32'(IDH));
    @(posedge clk_sys);
    config_button <= 1'b1;
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (8) tick;
    chk(32'(status_led), 32'h0000_0001);
    repeat (15) tick;
    chk(32'(status_led), 32'h0000_0001);
    n = 0;
    repeat (60) begin
      w[0] = status_led;
      tick;
      n += (status_led !== w[0]);
    end
    chk(32'(n >= 8), 32'h0000_0001);
    repeat (40) tick;
    n = 0;
    repeat (10) begin
      tick;
      n += (status_led !== 1'b1);
    end
    chk(32'(n), 32'h0000_0000);
    wr(ADDR_STATION, 16'h0007, 8'h00);
    @(posedge clk_sys);
    config_button <= 1'b0;
    n = 0;
    while (restart_pulse !== 1'b1 && n < 10) begin
      tick;
      n++;
    end
    chk(32'(n < 10), 32'h0000_0001);
    tick;
    chk(link_cfg, 32'h4b00_0001);
    rd(ADDR_STATION, 16'h0001);
    test_done;
  end
endmodule : tb

bind temp_sensor_regmap regmap_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn), .req(req), .resp(resp),
  .comm_frame(comm_frame), .config_button(config_button), .temp_celsius_in(temp_celsius_in),
  .temp_fahrenheit_in(temp_fahrenheit_in), .temp_valid(temp_valid), .station_address(station_address),
  .link_cfg(link_cfg), .status_led(status_led), .restart_pulse(restart_pulse));
